// [rtl/pct_defines.svh]
// constants of the counter timebase block: offsets, fields, resets, divisors
// assumes byte-wide registers on a plain strobe port
`ifndef PCT_DEFINES_SVH
`define PCT_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define PCT_OFF_COUNT_LOW 8'h00
`define PCT_OFF_COUNT_HIGH 8'h01
`define PCT_OFF_MODE 8'h02
`define PCT_OFF_STATUS 8'h03
`define PCT_OFF_CLEAR 8'h04
`define PCT_OFF_ENABLE 8'h05

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PCT_MODE_IDLE_BIT 7
`define PCT_MODE_SEL_MSB 3
`define PCT_MODE_SEL_LSB 1
`define PCT_IRQ_OVF_BIT 0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PCT_COUNT_RST 16'h0000
`define PCT_SEL_RST 3'h0
`define PCT_IDLE_RST 1'b0
`define PCT_ENABLE_RST 1'b0

// ------------------------------------------------------------
// timing counts in system clocks or source edges
// ------------------------------------------------------------
`define PCT_DIV_SLOW 4'hC
`define PCT_DIV_MID 4'h4
`define PCT_DIV_OSC 4'h8
`define PCT_COUNT_MAX 16'hFFFF

`endif

// [rtl/pct_pkg.sv]
// types of the counter timebase block
// assumes the constants header is included by the modules
package pct_pkg;

  // ------------------------------------------------------------
  // timebase select codes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PCT_TB_DIV12 = 3'h0,
    PCT_TB_DIV4 = 3'h1,
    PCT_TB_T0 = 3'h2,
    PCT_TB_EXT = 3'h3,
    PCT_TB_SYS = 3'h4,
    PCT_TB_XOSC = 3'h5,
    PCT_TB_LFO = 3'h6,
    PCT_TB_RSVD = 3'h7
  } pct_tb_sel_t;

  // ------------------------------------------------------------
  // register port request
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pct_bus_req_t;

endpackage

// [rtl/pct_edge_sync.sv]
// three-stage synchroniser with debounced rise and fall pulses
// assumes the input toggles slower than a quarter of clk
`timescale 1ns/1ps

module pct_edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic rise,
  output logic fall
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  wire agree = (s2_r == s3_r);

  // ------------------------------------------------------------
  // stages and settled level
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end else if (ce) begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        lvl_r <= s3_r;
      end
    end
  end

  // single-cycle pulses once the change has settled [RL12]
  assign rise = agree && s3_r && !lvl_r;
  assign fall = agree && !s3_r && lvl_r;

endmodule

// [rtl/pct_counter_timebase.sv]
// 16-bit counter with selectable timebase, snapshot reads and overflow interrupt
// assumes a byte register port with read data one cycle after the strobe
//
// Overview of operation
// RL1: sixteen-bit up-counter seen as two bytes
// RL2: low-byte read snapshots high byte for later
// RL3: reads never disturb the counting
// RL4: software reads low byte before high byte
// RL5: codes 0,1,2,4 pick div12, div4, t0, clk
// RL6: code 3 counts falling external input edges
// RL7: codes 5,6 oscillator div8; 7 reserved
// RL8: wrap from maximum to zero sets overflow flag
// RL9: enabled overflow flag raises interrupt request
// RL10: flag stays set until software clears it
// RL11: idle suspend bit stops counting in idle
// RL12: async sources synchronised to single-cycle enables
// RL13: live count and advance pulse offered outward
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "pct_defines.svh"

module pct_counter_timebase #(
  parameter int PRESC_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire pct_pkg::pct_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic cpu_idle,
  input wire logic t0_ovf,
  input wire logic ext_count_input,
  input wire logic ext_osc_in,
  input wire logic lfo_osc_in,
  output logic irq,
  output logic [15:0] count_value,
  output logic count_adv
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [7:0] snap_r;
  pct_pkg::pct_tb_sel_t sel_r;
  logic idle_suspend_r;
  logic overflow_flag_r;
  logic overflow_flag_nxt;
  logic irq_en_r;
  logic [PRESC_W-1:0] presc_r;
  logic [2:0] xosc_div_r;
  logic [2:0] lfo_div_r;
  logic adv_r;
  logic irq_r;
  logic [7:0] rdata_r;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic div_hit(input logic [3:0] cnt, input logic [3:0] div);
    div_hit = (cnt >= div - 4'h1);
  endfunction

  function automatic logic tb_pick(input pct_pkg::pct_tb_sel_t sel,
                                   input logic slow, input logic mid,
                                   input logic t0, input logic ext,
                                   input logic xosc, input logic lfo);
    tb_pick = 1'b0;
    unique case (sel)
      pct_pkg::PCT_TB_DIV12: tb_pick = slow;
      pct_pkg::PCT_TB_DIV4: tb_pick = mid;
      pct_pkg::PCT_TB_T0: tb_pick = t0;
      pct_pkg::PCT_TB_EXT: tb_pick = ext;
      pct_pkg::PCT_TB_SYS: tb_pick = 1'b1;
      pct_pkg::PCT_TB_XOSC: tb_pick = xosc;
      pct_pkg::PCT_TB_LFO: tb_pick = lfo;
      pct_pkg::PCT_TB_RSVD: tb_pick = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire rd_low = bus_req.rd && (bus_req.addr == `PCT_OFF_COUNT_LOW);
  wire rd_high = bus_req.rd && (bus_req.addr == `PCT_OFF_COUNT_HIGH);
  wire wr_low = bus_req.wr && (bus_req.addr == `PCT_OFF_COUNT_LOW);
  wire wr_high = bus_req.wr && (bus_req.addr == `PCT_OFF_COUNT_HIGH);
  wire wr_mode = bus_req.wr && (bus_req.addr == `PCT_OFF_MODE);
  wire wr_clear = bus_req.wr && (bus_req.addr == `PCT_OFF_CLEAR);
  wire wr_enable = bus_req.wr && (bus_req.addr == `PCT_OFF_ENABLE);
  wire wr_count = wr_low || wr_high;
  wire clr_ovf = wr_clear && bus_req.wdata[`PCT_IRQ_OVF_BIT];

  // ------------------------------------------------------------
  // timebase sources
  // ------------------------------------------------------------
  logic ext_fall;
  logic xosc_rise;
  logic lfo_rise;

  pct_edge_sync u_ext_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(ext_count_input),
    .rise(),
    .fall(ext_fall)
  );

  pct_edge_sync u_xosc_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(ext_osc_in),
    .rise(xosc_rise),
    .fall()
  );

  pct_edge_sync u_lfo_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(lfo_osc_in),
    .rise(lfo_rise),
    .fall()
  );

  // idle suspension freezes the prescalers too [RL11]
  wire run = !(idle_suspend_r && cpu_idle);
  wire [3:0] presc_lim = (sel_r == pct_pkg::PCT_TB_DIV12) ? `PCT_DIV_SLOW : `PCT_DIV_MID;
  wire presc_hit = div_hit(4'(presc_r), presc_lim);
  wire slow_tick = presc_hit && (sel_r == pct_pkg::PCT_TB_DIV12);
  wire mid_tick = presc_hit && (sel_r == pct_pkg::PCT_TB_DIV4);
  wire xosc_tick = xosc_rise && div_hit({1'b0, xosc_div_r}, `PCT_DIV_OSC);
  wire lfo_tick = lfo_rise && div_hit({1'b0, lfo_div_r}, `PCT_DIV_OSC);

  // source selection [RL5] [RL6] [RL7]
  wire src_tick = tb_pick(sel_r, slow_tick, mid_tick, t0_ovf, ext_fall, xosc_tick, lfo_tick);
  wire adv = run && src_tick;
  wire wrap = adv && !wr_count && (count_r == `PCT_COUNT_MAX);

  // count update: reads play no part [RL1] [RL3]
  assign count_nxt = wr_low ? {count_r[15:8], bus_req.wdata} :
                     wr_high ? {bus_req.wdata, count_r[7:0]} :
                     adv ? count_r + 16'h0001 : count_r;

  // set wins over a same-cycle clear; only software clears [RL8] [RL10]
  assign overflow_flag_nxt = wrap || (overflow_flag_r && !clr_ovf);

  wire [7:0] mode_rd = {idle_suspend_r, 3'h0, sel_r, 1'b0};
  wire [7:0] read_mux = rd_high ? snap_r :
                        rd_low ? count_r[7:0] :
                        (bus_req.addr == `PCT_OFF_MODE) ? mode_rd :
                        (bus_req.addr == `PCT_OFF_STATUS) ? {7'h00, overflow_flag_r} :
                        (bus_req.addr == `PCT_OFF_ENABLE) ? {7'h00, irq_en_r} : 8'h00;

  // ------------------------------------------------------------
  // counter and snapshot
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= `PCT_COUNT_RST;
      snap_r <= 8'h00;
      adv_r <= 1'b0;
    end else if (ce) begin
      count_r <= count_nxt;
      adv_r <= adv && !wr_count;
      if (rd_low) begin
        snap_r <= count_r[15:8]; // [RL2]
      end
    end
  end

  // ------------------------------------------------------------
  // prescalers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      presc_r <= '0;
      xosc_div_r <= 3'h0;
      lfo_div_r <= 3'h0;
    end else if (ce && run) begin
      presc_r <= presc_hit ? '0 : presc_r + 1'b1;
      if (xosc_rise) begin
        xosc_div_r <= xosc_div_r + 3'h1;
      end
      if (lfo_rise) begin
        lfo_div_r <= lfo_div_r + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // control, flag, interrupt, read data
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_r <= pct_pkg::pct_tb_sel_t'(`PCT_SEL_RST);
      idle_suspend_r <= `PCT_IDLE_RST;
      irq_en_r <= `PCT_ENABLE_RST;
      overflow_flag_r <= 1'b0;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
    end else if (ce) begin
      if (wr_mode) begin
        sel_r <= pct_pkg::pct_tb_sel_t'(bus_req.wdata[`PCT_MODE_SEL_MSB:`PCT_MODE_SEL_LSB]);
        idle_suspend_r <= bus_req.wdata[`PCT_MODE_IDLE_BIT];
      end
      if (wr_enable) begin
        irq_en_r <= bus_req.wdata[`PCT_IRQ_OVF_BIT];
      end
      overflow_flag_r <= overflow_flag_nxt;
      irq_r <= overflow_flag_r && irq_en_r; // [RL9]
      rdata_r <= bus_req.rd ? read_mux : 8'h00;
    end
  end

  assign count_value = count_r; // [RL13]
  assign count_adv = adv_r;
  assign irq = irq_r;
  assign rdata = rdata_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_low_read;
    ce && rd_low;
  endsequence

  sequence s_high_read;
    ce && rd_high;
  endsequence

  a_snap_on_low: assert property (s_low_read |=> snap_r == $past(count_r[15:8])) // [RL2]
    else $error("snapshot missed the high byte");

  a_high_from_snap: assert property (s_low_read ##1 (s_high_read and !rd_low) // [RL2]
                                     |=> rdata_r == $past(count_r[15:8], 2))
    else $error("high read did not return snapshot");

  a_step_by_one: assert property (ce && adv && !wr_count |=> count_r == $past(count_r) + 16'h0001) // [RL1]
    else $error("counter did not advance by one");

  a_read_no_stop: assert property (ce && bus_req.rd && !adv |=> $stable(count_r)) // [RL3]
    else $error("read disturbed the counter");

  a_wrap_sets_flag: assert property (ce && wrap |=> overflow_flag_r && count_r == 16'h0000) // [RL8]
    else $error("wrap did not set overflow flag");

  a_flag_sticky: assert property (ce && overflow_flag_r && !clr_ovf |=> overflow_flag_r) // [RL10]
    else $error("overflow flag dropped by itself");

  a_irq_gate: assert property (ce && overflow_flag_r && irq_en_r |=> irq_r) // [RL9]
    else $error("enabled flag raised no interrupt");

  a_irq_masked: assert property (ce && !irq_en_r |=> !irq_r) // [RL9]
    else $error("masked flag raised interrupt");

  a_idle_hold: assert property (ce && cpu_idle && idle_suspend_r && !wr_count // [RL11]
                                |=> $stable(count_r))
    else $error("counter moved while suspended");

  a_sys_every: assert property (ce && run && sel_r == pct_pkg::PCT_TB_SYS && !wr_count // [RL5]
                                |=> count_adv)
    else $error("system clock timebase skipped a count");

  a_div12_spacing: assert property (ce && adv && sel_r == pct_pkg::PCT_TB_DIV12 // [RL5]
                                    |-> presc_r == 4'(`PCT_DIV_SLOW - 4'h1))
    else $error("divide-by-12 tick at wrong phase");

  a_ext_edge: assert property (ce && adv && sel_r == pct_pkg::PCT_TB_EXT |-> ext_fall) // [RL6]
    else $error("external count without falling edge");

  a_rsvd_idle: assert property (ce && sel_r == pct_pkg::PCT_TB_RSVD && !wr_count // [RL7]
                                |=> $stable(count_r))
    else $error("reserved timebase advanced counter");

  a_snap_hold: assert property (!(ce && rd_low) |=> $stable(snap_r)) // [RL2]
    else $error("snapshot changed without a low read");

  a_low_write: assert property (ce && wr_low |=> count_r[7:0] == $past(bus_req.wdata)) // [RL1]
    else $error("low byte write did not land");

  a_high_write: assert property (ce && wr_high // [RL1]
                                 |=> count_r[15:8] == $past(bus_req.wdata))
    else $error("high byte write did not land");

  a_adv_pulse: assert property (count_adv && $past(ce) // [RL13]
                                |-> count_r == $past(count_r) + 16'h0001)
    else $error("advance pulse without a single step");

  a_clear_drops: assert property (ce && clr_ovf && !wrap |=> !overflow_flag_r) // [RL10]
    else $error("clear left overflow flag set");

  a_irq_follows: assert property (ce && !overflow_flag_r |=> !irq_r) // [RL9]
    else $error("interrupt without overflow flag");

  a_t0_count: assert property (ce && run && t0_ovf && !wr_count // [RL5]
                               && sel_r == pct_pkg::PCT_TB_T0 |=> count_adv)
    else $error("timer 0 overflow not counted");

  a_osc_eighth: assert property (ce && adv && sel_r == pct_pkg::PCT_TB_XOSC // [RL7]
                                 |-> xosc_div_r == 3'h7)
    else $error("external oscillator count not on eighth edge");

  a_lfo_eighth: assert property (ce && adv && sel_r == pct_pkg::PCT_TB_LFO // [RL7]
                                 |-> lfo_div_r == 3'h7)
    else $error("low-frequency oscillator count not on eighth edge");

endmodule

// [testbench/tb_top.sv]
// directed testbench for the counter timebase block over its byte register port
// assumes the design header is on the include path and a 125 MHz clock
`timescale 1ns/1ps
`include "pct_defines.svh"

module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [7:0] A_LO = `PCT_OFF_COUNT_LOW;
  localparam logic [7:0] A_HI = `PCT_OFF_COUNT_HIGH;
  localparam logic [7:0] A_MD = `PCT_OFF_MODE;
  localparam logic [7:0] A_ST = `PCT_OFF_STATUS;
  localparam logic [7:0] A_CL = `PCT_OFF_CLEAR;
  localparam logic [7:0] A_EN = `PCT_OFF_ENABLE;
  logic clk;
  logic rst;
  logic ce;
  pct_pkg::pct_bus_req_t req;
  logic [7:0] rdata;
  logic cpu_idle;
  logic [3:0] src;
  logic irq;
  logic [15:0] count_value;
  logic count_adv;
  logic [7:0] rv;
  logic [15:0] v;
  int k;
  int failures = 0;
  int checked = 0;

  pct_counter_timebase #(.PRESC_W(4)) dut (
    .clk(clk), .rst(rst), .ce(ce), .bus_req(req), .rdata(rdata),
    .cpu_idle(cpu_idle), .t0_ovf(src[3]), .ext_count_input(src[0]),
    .ext_osc_in(src[1]), .lfo_osc_in(src[2]), .irq(irq),
    .count_value(count_value), .count_adv(count_adv)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk({8'h00, rv}, {8'h00, exp});
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
    v = count_value;
  endtask

  task automatic after(input int n, input logic [15:0] exp);
    repeat (n) @(posedge clk);
    #1;
    chk(count_value, exp);
  endtask

  task automatic wait_adv(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (count_adv !== 1'b1 && n < 40);
  endtask

  task automatic gap(input logic [2:0] s, input int per);
    int n;
    wr(A_MD, {4'h0, s, 1'b0});
    repeat (3) wait_adv(n);
    chk(16'(n), 16'(per));
  endtask

  task automatic wave(input int i, input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge clk);
      src[i] <= 1'b1;
      repeat (hold) @(posedge clk);
      src[i] <= 1'b0;
    end
  endtask

  task automatic ev(input logic [2:0] s, input int i, input int n, input int hold,
                    input logic [15:0] inc);
    wr(A_MD, {4'h0, s, 1'b0});
    settle();
    wave(i, n, hold);
    after(10, v + inc);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    cpu_idle = 1'b0;
    src = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(A_MD, 8'h00);
    rchk(A_ST, 8'h00);
    rchk(A_EN, 8'h00);
    rchk(A_CL, 8'h00);
    rchk(8'h06, 8'h00);
    wr(A_MD, 8'hFF);
    rchk(A_MD, 8'h8E);
    $display("test registers done");
    wr(A_MD, 8'h0E);
    wr(A_LO, 8'h56);
    wr(A_HI, 8'h34);
    rchk(A_LO, 8'h56);
    wr(A_HI, 8'h78);
    rchk(A_HI, 8'h34);
    rchk(A_LO, 8'h56);
    rchk(A_HI, 8'h78);
    chk(count_value, 16'h7856);
    $display("test snapshot done");
    gap(3'h0, 12);
    gap(3'h1, 4);
    gap(3'h4, 1);
    ev(3'h2, 3, 3, 1, 16'h0003);
    ev(3'h3, 0, 4, 6, 16'h0004);
    ev(3'h5, 1, 16, 6, 16'h0002);
    ev(3'h6, 2, 16, 6, 16'h0002);
    ev(3'h7, 0, 4, 6, 16'h0000);
    $display("test timebase done");
    wr(A_MD, 8'h88);
    cpu_idle <= 1'b1;
    settle();
    after(10, v);
    wr(A_MD, 8'h08);
    settle();
    after(10, v + 16'h000A);
    @(posedge clk);
    cpu_idle <= 1'b0;
    ce <= 1'b0;
    settle();
    after(10, v);
    @(posedge clk);
    ce <= 1'b1;
    $display("test idle done");
    wr(A_MD, 8'h0E);
    wr(A_LO, 8'hF0);
    wr(A_HI, 8'hFF);
    wr(A_EN, 8'h01);
    rchk(A_EN, 8'h01);
    wr(A_MD, 8'h08);
    settle();
    rd(A_LO, rv);
    rchk(A_HI, 8'hFF);
    chk(count_value, v + 16'h0004);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (count_value !== 16'h0000 && k < 60);
    rchk(A_ST, 8'h01);
    chk({15'h0, irq}, 16'h0001);
    wr(A_EN, 8'h00);
    rchk(A_ST, 8'h01);
    chk({15'h0, irq}, 16'h0000);
    wr(A_EN, 8'h01);
    wr(A_CL, 8'h00);
    wr(A_ST, 8'h00);
    rchk(A_ST, 8'h01);
    chk({15'h0, irq}, 16'h0001);
    wr(A_CL, 8'h01);
    rchk(A_ST, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    wr(A_MD, 8'h0E);
    $display("test overflow done");
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule
